// File: core/tsp_port.sv
// TDM serial port with control timeslot and two voice timeslots
//
// Contract
// - 32 slots of eight bits, 2048 kb/s
// - Frame start: sync low at clock fall
// - Drive at cell start, sample later
// - Slot timing runs on bit clock
// - Only slots 1, 2, 3 used
// - Three slot enable bits, slot 3 voice bit ignored while slot 2 voice bit set
// - Control byte sent in slot 1, else tri-state
// - Slot 1 byte always captured
// - Control bytes shifted MSB first
// - Control register double-buffered, accessed anytime
// - Voice slot sends PCM, else zeros
// - Both voice enables: slot 2 only
// - Enabled voice slot PCM passed inward
// - Slot 2 first voice, slot 3 second
// - Write loads transmit, read returns received
`timescale 1ns/1ps

module tsp_port
(
   // Core clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Register access
   input wire tsp_pkg::tsp_reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   // Serial link
   input wire logic double_rate_bit_clock_i,
   input wire logic frame_sync_n_i,
   input wire logic tdm_rx_stream_i,
   output logic tdm_tx_stream_o,
   output logic tdm_tx_stream_oe_o,
   // Voice path, on the bit clock
   input wire logic [7:0] pcm_tx_data_i,
   output logic [7:0] pcm_rx_data_o,
   output logic pcm_rx_valid_o
);

   ////////////////////////////////////////////////////////////////////////
   // State types

   typedef struct packed {
      logic [7:0] ctl_tx;
      logic [7:0] ctl_hold;
      logic ctl_req;
      logic ctl_pend;
      logic ack_s1;
      logic ack_s2;
      logic rx_s1;
      logic rx_s2;
      logic rx_seen;
      logic [7:0] ctl_rx;
      logic [tsp_pkg::EN_WIDTH-1:0] ts_en;
      logic [7:0] rdata;
   } tsp_core_t;

   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic req_s1;
      logic req_s2;
      logic ctl_ack;
      logic [tsp_pkg::EN_WIDTH-1:0] en_s1;
      logic [tsp_pkg::EN_WIDTH-1:0] en_s2;
      logic framed;
      logic [tsp_pkg::CNT_W-1:0] cnt;
      logic [7:0] ctl_stage;
      logic [7:0] ctl_shift;
      logic [7:0] pcm_hold;
      logic [6:0] rx_shift;
      logic [7:0] ctl_rx_hold;
      logic rx_tog;
      logic tx_d;
      logic tx_oe;
      logic [7:0] pcm_rx;
      logic pcm_rx_vld;
   } tsp_link_t;

   tsp_core_t c;
   tsp_core_t next_c;
   tsp_link_t l;
   tsp_link_t next_l;

   ////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   // Timeslot number of a frame edge count
   function automatic logic [4:0] slot_of
   (
      input logic [tsp_pkg::CNT_W-1:0] cnt
   );
      slot_of = cnt[8:4];
   endfunction

   // Bit index within the slot, 0 is the first bit sent
   function automatic logic [2:0] bit_of
   (
      input logic [tsp_pkg::CNT_W-1:0] cnt
   );
      bit_of = cnt[3:1];
   endfunction

   // Voice slot active for the given slot and enables
   function automatic logic voice_on
   (
      input logic [4:0] slot,
      input logic [tsp_pkg::EN_WIDTH-1:0] en
   );
      logic a;
      logic b;
      a = en[tsp_pkg::EN_VOICE_A_BIT];
      b = en[tsp_pkg::EN_VOICE_B_BIT];
      if (slot == tsp_pkg::SLOT_VOICE_A)
      begin
         voice_on = a;
      end
      else if (slot == tsp_pkg::SLOT_VOICE_B)
      begin
         voice_on = b && !a;
      end
      else
      begin
         voice_on = 1'b0;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Core domain: registers and crossings

   always_comb
   begin
      next_c = c;
      next_c.ack_s1 = l.ctl_ack;
      next_c.ack_s2 = c.ack_s1;
      next_c.rx_s1 = l.rx_tog;
      next_c.rx_s2 = c.rx_s1;
      // Hand the pending byte over only when the last one was taken
      if (c.ctl_pend && (c.ctl_req == c.ack_s2))
      begin
         next_c.ctl_hold = c.ctl_tx;
         next_c.ctl_req = !c.ctl_req;
         next_c.ctl_pend = 1'b0;
      end
      if (reg_req_i.wr)
      begin
         if (reg_req_i.addr == tsp_pkg::ADDR_CTL_SLOT)
         begin
            next_c.ctl_tx = reg_req_i.wdata;
            next_c.ctl_pend = 1'b1;
         end
         if (reg_req_i.addr == tsp_pkg::ADDR_TS_ENABLE)
         begin
            next_c.ts_en = reg_req_i.wdata[tsp_pkg::EN_WIDTH-1:0];
         end
      end
      // Link hold stays stable for a frame, far beyond the sync delay
      if (c.rx_s2 != c.rx_seen)
      begin
         next_c.rx_seen = c.rx_s2;
         next_c.ctl_rx = l.ctl_rx_hold;
      end
      if (reg_req_i.rd)
      begin
         if (reg_req_i.addr == tsp_pkg::ADDR_CTL_SLOT)
         begin
            next_c.rdata = c.ctl_rx;
         end
         else if (reg_req_i.addr == tsp_pkg::ADDR_TS_ENABLE)
         begin
            next_c.rdata = {5'h00, c.ts_en};
         end
         else
         begin
            next_c.rdata = tsp_pkg::READ_UNMAPPED;
         end
      end
      if (!rstn_i)
      begin
         next_c = '0;
         next_c.ctl_tx = tsp_pkg::CTL_SLOT_RESET;
         next_c.ctl_hold = tsp_pkg::CTL_SLOT_RESET;
         next_c.ctl_rx = tsp_pkg::CTL_SLOT_RESET;
         next_c.ts_en = tsp_pkg::TS_ENABLE_RESET;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      c <= next_c;
   end

   assign reg_rdata_o = c.rdata;

   ////////////////////////////////////////////////////////////////////////
   // Link domain, on falling edges of the bit clock

   always_comb
   begin
      logic [tsp_pkg::CNT_W-1:0] cur;
      logic [4:0] slot;
      logic [2:0] bidx;
      logic [7:0] byte_in;
      logic [7:0] pcm_byte;
      cur = '0;
      slot = '0;
      bidx = '0;
      byte_in = '0;
      pcm_byte = '0;
      next_l = l;
      next_l.rst_s1 = rstn_i;
      next_l.rst_s2 = l.rst_s1;
      next_l.req_s1 = c.ctl_req;
      next_l.req_s2 = l.req_s1;
      next_l.en_s1 = c.ts_en;
      next_l.en_s2 = l.en_s1;
      next_l.pcm_rx_vld = 1'b0;
      // Newly written byte is staged, not yet sent
      if (l.req_s2 != l.ctl_ack)
      begin
         next_l.ctl_stage = c.ctl_hold;
         next_l.ctl_ack = l.req_s2;
      end
      // Frame pulse resynchronises the edge count
      if (!frame_sync_n_i)
      begin
         cur = '0;
         next_l.framed = 1'b1;
      end
      else
      begin
         cur = l.cnt + 1'b1;
      end
      next_l.cnt = cur;
      slot = slot_of(cur);
      bidx = bit_of(cur);
      if (cur == '0)
      begin
         next_l.ctl_shift = l.ctl_stage;
      end
      if (!cur[0])
      begin
         // Even edge: start of a bit cell, drive the output
         next_l.tx_d = 1'b0;
         next_l.tx_oe = 1'b0;
         pcm_byte = (bidx == 3'h0) ? pcm_tx_data_i : l.pcm_hold;
         if (bidx == 3'h0)
         begin
            next_l.pcm_hold = pcm_tx_data_i;
         end
         if (next_l.framed && (slot == tsp_pkg::SLOT_CTL))
         begin
            next_l.tx_oe = l.en_s2[tsp_pkg::EN_CTL_BIT];
            next_l.tx_d = l.en_s2[tsp_pkg::EN_CTL_BIT] &&
               l.ctl_shift[3'h7 - bidx];
         end
         if (next_l.framed && ((slot == tsp_pkg::SLOT_VOICE_A) ||
            (slot == tsp_pkg::SLOT_VOICE_B)))
         begin
            next_l.tx_oe = 1'b1;
            next_l.tx_d = voice_on(slot, l.en_s2) &&
               pcm_byte[3'h7 - bidx];
         end
      end
      else
      begin
         // Odd edge: late in the cell, sample the input
         next_l.rx_shift = {l.rx_shift[5:0], tdm_rx_stream_i};
         byte_in = {l.rx_shift, tdm_rx_stream_i};
         if (l.framed && (bidx == tsp_pkg::BIT_LAST))
         begin
            if (slot == tsp_pkg::SLOT_CTL)
            begin
               next_l.ctl_rx_hold = byte_in;
               next_l.rx_tog = !l.rx_tog;
            end
            if (voice_on(slot, l.en_s2))
            begin
               next_l.pcm_rx = byte_in;
               next_l.pcm_rx_vld = 1'b1;
            end
         end
      end
      if (!l.rst_s2)
      begin
         next_l = '0;
         next_l.rst_s1 = rstn_i;
         next_l.rst_s2 = l.rst_s1;
         next_l.ctl_stage = tsp_pkg::CTL_SLOT_RESET;
         next_l.ctl_shift = tsp_pkg::CTL_SLOT_RESET;
         next_l.ctl_rx_hold = tsp_pkg::CTL_SLOT_RESET;
      end
   end

   // Bit cell starts on the falling edge, so the link runs on it
   always_ff @(negedge double_rate_bit_clock_i)
   begin
      l <= next_l;
   end

   assign tdm_tx_stream_o = l.tx_d;
   assign tdm_tx_stream_oe_o = l.tx_oe;
   assign pcm_rx_data_o = l.pcm_rx;
   assign pcm_rx_valid_o = l.pcm_rx_vld;

endmodule

// File: core/tsp_pkg.sv
// Constants and carrier types of the TDM serial port
package tsp_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [7:0] ADDR_CTL_SLOT = 8'h14;
   localparam logic [7:0] ADDR_TS_ENABLE = 8'h15;

   // Timeslot enable register fields
   localparam int EN_CTL_BIT = 0;
   localparam int EN_VOICE_A_BIT = 1;
   localparam int EN_VOICE_B_BIT = 2;
   localparam int EN_WIDTH = 3;

   // Reset values
   localparam logic [7:0] CTL_SLOT_RESET = 8'h00;
   localparam logic [EN_WIDTH-1:0] TS_ENABLE_RESET = 3'h0;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Frame layout
   localparam int SLOTS_PER_FRAME = 32;
   localparam int BITS_PER_SLOT = 8;
   localparam int EDGES_PER_BIT = 2;
   localparam int EDGES_PER_FRAME =
      SLOTS_PER_FRAME * BITS_PER_SLOT * EDGES_PER_BIT;
   localparam int CNT_W = $clog2(EDGES_PER_FRAME);
   localparam logic [4:0] SLOT_CTL = 5'h01;
   localparam logic [4:0] SLOT_VOICE_A = 5'h02;
   localparam logic [4:0] SLOT_VOICE_B = 5'h03;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // Timing of the link
   localparam int DATA_RATE_KBPS = 2048;
   localparam int BIT_CLK_KHZ = DATA_RATE_KBPS * EDGES_PER_BIT;
   localparam int FRAME_PERIOD_NS = 125000;
   localparam int FRAME_SYNC_NS = 244;

   ////////////////////////////////////////////////////////////////////////
   // Register request carrier
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tsp_reg_req_t;

endpackage

// File: test/tsp_port_sva.sv
// Timing checker of the TDM serial port
`timescale 1ns/1ps
module tsp_port_chk
(
   // Core side
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire tsp_pkg::tsp_reg_req_t reg_req_i,
   input wire logic [7:0] reg_rdata_o,
   // Link side
   input wire logic double_rate_bit_clock_i,
   input wire logic frame_sync_n_i,
   input wire logic tdm_tx_stream_o,
   input wire logic tdm_tx_stream_oe_o,
   input wire logic pcm_rx_valid_o
);
   wire lk = double_rate_bit_clock_i;
   wire rst = !rstn_i;
   wire vld = pcm_rx_valid_o;
   wire oe = tdm_tx_stream_oe_o;
   wire rd = reg_req_i.rd;
   logic [8:0] pos;
   logic sy;
   // Outputs seen at an edge were launched one edge earlier
   always_ff @(negedge lk)
   begin
      pos <= frame_sync_n_i ? pos + 9'h001 : 9'h001;
      sy <= rstn_i && (sy || !frame_sync_n_i);
   end
   wire used = sy && pos >= 9'h011 && pos <= 9'h040;
   wire voice = sy && pos >= 9'h021 && pos <= 9'h040;
   ////////////////////////////////////////////////////////////
   chk_idle_oe_off: assert property (@(negedge lk) disable iff (rst)
      !used |-> !oe) else $error("oe outside used slots");
   chk_voice_oe_on: assert property (@(negedge lk) disable iff (rst)
      voice |-> oe) else $error("voice slot not driven");
   chk_bit_cell: assert property (@(negedge lk) disable iff (rst)
      used && oe && !pos[0] |-> $stable(tdm_tx_stream_o))
      else $error("bit changed mid cell");
   chk_pcm_when: assert property (@(negedge lk) disable iff (rst)
      vld |-> sy && (pos == 9'h030 || pos == 9'h040))
      else $error("voice byte at wrong edge");
   chk_pcm_pulse: assert property (@(negedge lk) disable iff (rst)
      vld |=> !vld) else $error("voice strobe too long");
   chk_one_voice: assert property (@(negedge lk) disable iff (rst)
      sy && pos == 9'h040 && $past(vld, 16) |-> !vld)
      else $error("two voice slots in a frame");
   chk_rdata_hold: assert property (@(posedge core_clk_i)
      disable iff (rst) !$past(rd) |-> $stable(reg_rdata_o))
      else $error("read data moved");
   chk_unmapped_zero: assert property (@(posedge core_clk_i)
      disable iff (rst) rd && reg_req_i.addr != tsp_pkg::ADDR_CTL_SLOT &&
      reg_req_i.addr != tsp_pkg::ADDR_TS_ENABLE
      |=> reg_rdata_o == tsp_pkg::READ_UNMAPPED) else $error("unmapped read");
   chk_enable_top: assert property (@(posedge core_clk_i)
      disable iff (rst) rd && reg_req_i.addr == tsp_pkg::ADDR_TS_ENABLE
      |=> reg_rdata_o[7:3] == 5'h00) else $error("enable top bits set");
   cov_slot_a: cover property (@(negedge lk) vld && pos == 9'h030);
   cov_slot_b: cover property (@(negedge lk) vld && pos == 9'h040);
   cov_ctl_on: cover property (@(negedge lk) used && pos == 9'h011 && oe);
endmodule

bind tsp_port tsp_port_chk tsp_port_chk_i (.core_clk_i, .rstn_i, .reg_req_i,
   .reg_rdata_o, .double_rate_bit_clock_i, .frame_sync_n_i, .tdm_tx_stream_o,
   .tdm_tx_stream_oe_o, .pcm_rx_valid_o);

// File: test/tsp_far.sv
// Far-end transceiver model of the TDM link
`timescale 1ns/1ps
module tsp_far
(
   // Link pins
   output logic clk_o,
   output logic fs_n_o,
   output logic rx_o,
   input wire logic tx_i,
   input wire logic oe_i,
   // Bench side
   input wire logic [7:0] ctl_i,
   input wire logic [7:0] pcm_i,
   output logic [3:1][7:0] got_o,
   output logic [3:1] drv_o,
   output logic [7:0] frames_o
);
   logic [8:0] c = 9'h000;
   wire [1:0] s = c[5:4];
   wire in_use = c[8:6] == 3'h0 && c[5:4] != 2'h0;
   wire [2:0] b = 3'h7 - c[3:1];
   // Bit clock runs free, it also times the device inside
   initial
   begin
      clk_o = 1'b0;
      fs_n_o = 1'b1;
      rx_o = 1'b0;
      frames_o = 8'h00;
      #7;
      forever #15 clk_o = ~clk_o;
   end
   always @(posedge clk_o)
      fs_n_o <= c != 9'h000;
   always @(negedge clk_o)
   begin
      c <= c + 9'h001;
      if (c == 9'h000)
         frames_o <= frames_o + 8'h01;
      // Unused slots toggle so no stale level looks valid
      if (!c[0])
         rx_o <= !in_use ? ~rx_o : s == 2'h1 ? ctl_i[b] :
            s == 2'h2 ? pcm_i[b] : ~pcm_i[b];
      else if (in_use)
      begin
         // A released line has no pull, so it reads as the inverse
         got_o[s] <= {got_o[s][6:0], oe_i ? tx_i : ~tx_i};
         drv_o[s] <= (b == 3'h7 || drv_o[s]) && oe_i;
      end
   end
endmodule

// File: test/testbench.sv
// Self-checking bench of the TDM serial port
`timescale 1ns/1ps
module testbench;
   logic core_clk_i, rstn_i, lclk, fs_n, rx, tx, oe, pcm_v;
   tsp_pkg::tsp_reg_req_t req;
   logic [7:0] rdata, pcm_rx, last_pcm, frames;
   // Bytes that read differently in either bit order, so order is tested
   logic [7:0] ctl = 8'h3a;
   logic [7:0] pcm_tx = 8'h1d;
   logic [7:0] pcm = 8'h36;
   logic [3:1][7:0] got;
   logic [3:1] drv;
   int errors = 0;
   int n_compared = 0;
   int npulse = 0;
   tsp_port tsp_port_i (.core_clk_i, .rstn_i, .reg_req_i(req),
      .reg_rdata_o(rdata), .double_rate_bit_clock_i(lclk),
      .frame_sync_n_i(fs_n), .tdm_rx_stream_i(rx), .tdm_tx_stream_o(tx),
      .tdm_tx_stream_oe_o(oe), .pcm_tx_data_i(pcm_tx),
      .pcm_rx_data_o(pcm_rx), .pcm_rx_valid_o(pcm_v));
   tsp_far tsp_far_i (.clk_o(lclk), .fs_n_o(fs_n), .rx_o(rx), .tx_i(tx),
      .oe_i(oe), .ctl_i(ctl), .pcm_i(pcm), .got_o(got), .drv_o(drv),
      .frames_o(frames));
   always @(negedge lclk)
      if (pcm_v)
      begin
         npulse <= npulse + 1;
         last_pcm <= pcm_rx;
      end
   ////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      req <= '{1'b1, 1'b0, a, d};
      @(negedge core_clk_i);
      req <= '0;
      @(negedge core_clk_i);
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(negedge core_clk_i);
      req <= '0;
      @(negedge core_clk_i);
      d = rdata;
   endtask
   task automatic wait_frames(input int n);
      logic [7:0] f0;
      int k;
      f0 = frames;
      for (k = 0; 8'(frames - f0) < n && k < 5000 * n; k++)
         @(negedge core_clk_i);
      if (k >= 5000 * n)
      begin
         errors++;
         complete_run();
      end
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [7:0] d;
      reg_rd(tsp_pkg::ADDR_TS_ENABLE, d);
      cmp(d, {5'h00, tsp_pkg::TS_ENABLE_RESET});
      reg_wr(8'h13, 8'hff);
      reg_rd(8'h13, d);
      cmp(d, tsp_pkg::READ_UNMAPPED);
      reg_wr(tsp_pkg::ADDR_TS_ENABLE, 8'hff);
      reg_rd(tsp_pkg::ADDR_TS_ENABLE, d);
      cmp(d, 8'h07);
   endtask
   // Written and received bytes differ, so a read of the sent byte fails
   task automatic t_ctl(input logic [7:0] en);
      logic [7:0] d;
      ctl = ~ctl;
      reg_wr(tsp_pkg::ADDR_TS_ENABLE, en);
      reg_wr(tsp_pkg::ADDR_CTL_SLOT, 8'h96 ^ en);
      wait_frames(3);
      cmp({7'h00, drv[1]}, en);
      if (en[0])
         cmp(got[1], 8'h97);
      reg_rd(tsp_pkg::ADDR_CTL_SLOT, d);
      cmp(d, ctl);
   endtask
   task automatic t_voice(input logic [7:0] en);
      int n0;
      pcm_tx = 8'h1d + en;
      reg_wr(tsp_pkg::ADDR_TS_ENABLE, en);
      wait_frames(2);
      // Pulse counter has one writer; count by difference over a frame
      n0 = npulse;
      wait_frames(1);
      cmp(got[2], en[1] ? pcm_tx : 8'h00);
      cmp(got[3], en[2:1] == 2'h2 ? pcm_tx : 8'h00);
      cmp({6'h00, drv[3:2]}, 8'h03);
      cmp(8'(npulse - n0), {7'h00, |en[2:1]});
      if (en[2:1] != 2'h0)
         cmp(last_pcm, en[1] ? pcm : ~pcm);
   endtask
   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   initial
   begin
      rstn_i = 1'b0;
      req = '0;
      repeat (8) @(negedge core_clk_i);
      rstn_i = 1'b1;
      t_regs();
      t_ctl(8'h01);
      t_ctl(8'h00);
      for (int i = 0; i < 4; i++)
         t_voice(8'(2 * i));
      complete_run();
   end
endmodule
